// ---- design/cpmc_pkg.sv ----
/*
 * Shared definitions for the clock path mode configuration block: register
 * indices, field positions, reset values, the update command and the packed
 * structs that carry configuration and decoded controls between modules.
 * Assumes a 32-bit APB register bus whose byte address is four times the
 * register index, because some indices are not multiples of four.
 */
package cpmc_pkg;

	// Register indices; the byte address on APB is the index times four.
	localparam logic [9:0] CPMC_IDX_PLL_CTRL = 10'h010;
	localparam logic [9:0] CPMC_IDX_VCO_DIV = 10'h1e0;
	localparam logic [9:0] CPMC_IDX_SRC_SEL = 10'h1e1;
	localparam logic [9:0] CPMC_IDX_UPDATE = 10'h232;
	localparam logic [9:0] CPMC_IDX_ACTIVE_STAT = 10'h240;

	// Field positions inside the 8-bit registers and, for the pending flag, the status word.
	localparam int unsigned CPMC_PWR_LSB = 0;
	localparam int unsigned CPMC_PUMP_LSB = 4;
	localparam int unsigned CPMC_POL_BIT = 7;
	localparam int unsigned CPMC_DIV_LSB = 0;
	localparam int unsigned CPMC_BYPASS_BIT = 0;
	localparam int unsigned CPMC_SRC_BIT = 1;
	localparam int unsigned CPMC_PEND_BIT = 24;

	// Encodings of the PLL power field.
	localparam logic [1:0] CPMC_PWR_NORMAL = 2'h0;
	localparam logic [1:0] CPMC_PWR_ASYNC_PD = 2'h1;

	// Value that must be written to the update register to apply settings.
	localparam logic [7:0] CPMC_UPDATE_CMD = 8'h01;

	// Values after reset: PLL off, divide by four, divider in use, external clock.
	localparam logic [7:0] CPMC_PLL_CTRL_RST = 8'h01;
	localparam logic [7:0] CPMC_VCO_DIV_RST = 8'h02;
	localparam logic [7:0] CPMC_SRC_SEL_RST = 8'h00;

	// One complete set of programmable configuration bytes.
	typedef struct packed {
		logic [7:0] pll_ctrl;
		logic [7:0] vco_div;
		logic [7:0] src_sel;
	} cpmc_cfg_s;

	localparam cpmc_cfg_s CPMC_CFG_RST = '{
		pll_ctrl: CPMC_PLL_CTRL_RST,
		vco_div: CPMC_VCO_DIV_RST,
		src_sel: CPMC_SRC_SEL_RST
	};

	// Decoded controls that steer the analog PLL and divider paths.
	typedef struct packed {
		logic pll_power_down;
		logic pll_normal;
		logic [2:0] loop_pump_mode;
		logic phase_detector_negative;
		logic [2:0] vco_div_sel;
		logic divider_bypass;
		logic source_internal;
	} cpmc_ctrl_s;

endpackage

// ---- design/cpmc_path_decode.sv ----
/*
 * Registered decoder that turns the active configuration into the control
 * levels of the PLL, the divider bypass mux and the clock source mux.
 * Assumes its configuration input changes only when an update is applied.
 */
`timescale 1ns/1ns

module cpmc_path_decode
	import cpmc_pkg::*;
(
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire cpmc_cfg_s cfg_in,
	output cpmc_ctrl_s ctrl_out
);

	// All state of this module: the registered control word.
	typedef struct packed {
		cpmc_ctrl_s ctrl;
	} cpmc_dec_state_s;

	// Decoded controls after reset, matching the reset configuration.
	localparam cpmc_ctrl_s CPMC_CTRL_RST = '{
		pll_power_down: 1'b1,
		pll_normal: 1'b0,
		loop_pump_mode: 3'h0,
		phase_detector_negative: 1'b0,
		vco_div_sel: CPMC_VCO_DIV_RST[2:0],
		divider_bypass: 1'b0,
		source_internal: 1'b0
	};

	cpmc_dec_state_s state_reg; // Current registered controls.
	cpmc_dec_state_s state_next; // Controls for the next edge.

	// Decode the active bytes into individual path controls.
	always_comb begin
		state_next = state_reg;
		// Field 01 powers the PLL down asynchronously; 00 runs it normally.
		state_next.ctrl.pll_power_down = (cfg_in.pll_ctrl[CPMC_PWR_LSB +: 2] == CPMC_PWR_ASYNC_PD);
		state_next.ctrl.pll_normal = (cfg_in.pll_ctrl[CPMC_PWR_LSB +: 2] == CPMC_PWR_NORMAL);
		state_next.ctrl.loop_pump_mode = cfg_in.pll_ctrl[CPMC_PUMP_LSB +: 3];
		// A set bit flips the detector sense for VCOs that slow as voltage rises.
		state_next.ctrl.phase_detector_negative = cfg_in.pll_ctrl[CPMC_POL_BIT];
		state_next.ctrl.vco_div_sel = cfg_in.vco_div[CPMC_DIV_LSB +: 3];
		// Bypass feeds the input clock straight to the distribution section.
		state_next.ctrl.divider_bypass = cfg_in.src_sel[CPMC_BYPASS_BIT];
		// A clear select bit keeps the external clock input as the source.
		state_next.ctrl.source_internal = cfg_in.src_sel[CPMC_SRC_BIT];
	end

	// Register the controls so the analog side sees glitch-free levels.
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			state_reg <= '{ctrl: CPMC_CTRL_RST};
		end else begin
			state_reg <= state_next;
		end
	end

	assign ctrl_out = state_reg.ctrl;

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (srst_in);

	chk_pll_power_decode: assert property (
		(cfg_in.pll_ctrl[1:0] == CPMC_PWR_ASYNC_PD) |=> ctrl_out.pll_power_down && !ctrl_out.pll_normal)
		else $error("PLL power-down field did not turn the PLL off.");
	chk_pll_normal_decode: assert property (
		(cfg_in.pll_ctrl[1:0] == CPMC_PWR_NORMAL) |=> ctrl_out.pll_normal && !ctrl_out.pll_power_down)
		else $error("PLL normal field did not turn the PLL on.");
	chk_bypass_route: assert property (
		ctrl_out.divider_bypass == $past(cfg_in.src_sel[CPMC_BYPASS_BIT]))
		else $error("Divider bypass does not follow the active select bit.");
	chk_detector_polarity: assert property (
		$changed(cfg_in.pll_ctrl[7]) |=> ctrl_out.phase_detector_negative == $past(cfg_in.pll_ctrl[7]))
		else $error("Phase detector polarity did not follow its bit.");
	chk_external_source: assert property (
		!cfg_in.src_sel[CPMC_SRC_BIT] |=> !ctrl_out.source_internal)
		else $error("External clock not selected while select bit is clear.");
	chk_reset_controls: assert property (
		$past(srst_in) |-> ctrl_out.pll_power_down && ctrl_out.vco_div_sel == 3'h2
			&& !ctrl_out.divider_bypass)
		else $error("Controls after reset are not PLL off, divide by four, divider used.");

endmodule

// ---- design/cpmc_clock_path_mode_config.sv ----
/*
 * Top of the clock path mode configuration block: an APB register slave
 * holding staged PLL, divider and source settings, an update register that
 * copies them into the active set in one cycle, and the path decoder.
 * Assumes a single 20 MHz clock, a synchronous active-high reset and an APB
 * master that keeps each request stable until pready is sampled high.
 */
// Design decision made here: the APB slave port.
`timescale 1ns/1ns

module cpmc_clock_path_mode_config
	import cpmc_pkg::*;
#(
	parameter int unsigned ADDR_W = 12
)
(
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	output logic pready_out,
	output logic [31:0] prdata_out,
	output logic pslverr_out,
	output cpmc_ctrl_s ctrl_out,
	output logic update_pending_out,
	output logic update_applied_out
);

	// All state of the block, registered as one word.
	typedef struct packed {
		cpmc_cfg_s staged; // Values software has written but not applied.
		cpmc_cfg_s active; // Values currently steering the clock path.
		logic pending; // A staged register has been written since the last update.
		logic applied; // One-cycle pulse after an update has been applied.
		logic ready; // Answer flag for the APB access phase.
		logic err; // Error answer for the APB access phase.
		logic [31:0] rdata; // Read data captured in the setup cycle.
	} cpmc_state_s;

	cpmc_state_s state_reg; // Current state.
	cpmc_state_s state_next; // State for the next edge.

	logic setup_phase; // APB setup cycle of any transfer.
	logic access_done; // Edge at which the current transfer completes.
	logic wr_fire; // A write takes effect at this edge.
	logic upd_fire; // A write of the update command takes effect at this edge.
	logic [31:0] rd_mux; // Read value for the addressed register.
	logic addr_mapped; // Address hits a register of this block.

	// True when the bus address selects the register with the given index.
	function automatic logic cpmc_hit(input logic [ADDR_W-1:0] addr, input logic [9:0] idx);
		cpmc_hit = (addr == ADDR_W'({idx, 2'b00}));
	endfunction

	// Merge byte lane zero of a write into an 8-bit register.
	function automatic logic [7:0] cpmc_merge(input logic [7:0] old_val,
		input logic [31:0] wdata, input logic [3:0] strb);
		cpmc_merge = strb[0] ? wdata[7:0] : old_val;
	endfunction

	// Bus phase decode; pready is registered so the access edge is its own.
	// The slave never stretches a transfer: one setup and one access cycle.
	// The price is that the read value is frozen in the setup cycle, so a
	// status read shows the state one edge before the access edge.
	always_comb begin
		setup_phase = psel_in && !penable_in;
		access_done = psel_in && penable_in && state_reg.ready;
		wr_fire = access_done && pwrite_in && !state_reg.err;
		// Only the exact command value applies; other values are ignored.
		upd_fire = wr_fire && cpmc_hit(paddr_in, CPMC_IDX_UPDATE) && pstrb_in[0]
			&& (pwdata_in[7:0] == CPMC_UPDATE_CMD);
	end

	// Address decode and read multiplexer, evaluated in the setup cycle.
	always_comb begin
		addr_mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		if (cpmc_hit(paddr_in, CPMC_IDX_PLL_CTRL)) begin
			rd_mux = {24'h00_0000, state_reg.staged.pll_ctrl};
		end else if (cpmc_hit(paddr_in, CPMC_IDX_VCO_DIV)) begin
			rd_mux = {24'h00_0000, state_reg.staged.vco_div};
		end else if (cpmc_hit(paddr_in, CPMC_IDX_SRC_SEL)) begin
			rd_mux = {24'h00_0000, state_reg.staged.src_sel};
		end else if (cpmc_hit(paddr_in, CPMC_IDX_UPDATE)) begin
			// The trigger acts on the write only and always reads back as zero.
			rd_mux = 32'h0000_0000;
		end else if (cpmc_hit(paddr_in, CPMC_IDX_ACTIVE_STAT)) begin
			// Shows what the hardware is actually using, plus the pending flag.
			rd_mux = {7'h00, state_reg.pending, state_reg.active};
		end else begin
			addr_mapped = 1'b0;
		end
	end

	// Next-state logic for the register file, the update and the bus answer.
	always_comb begin
		state_next = state_reg;
		state_next.applied = 1'b0;
		// Answer every transfer in its first access cycle: no wait states.
		if (setup_phase) begin
			state_next.ready = 1'b1;
			state_next.rdata = pwrite_in ? 32'h0000_0000 : rd_mux;
			// Unmapped addresses and writes to the read-only status answer with an error.
			state_next.err = !addr_mapped
				|| (pwrite_in && cpmc_hit(paddr_in, CPMC_IDX_ACTIVE_STAT));
		end else if (access_done) begin
			state_next.ready = 1'b0;
			state_next.err = 1'b0;
		end
		// Writes land in the staging copy only and never touch the live path.
		if (wr_fire) begin
			if (cpmc_hit(paddr_in, CPMC_IDX_PLL_CTRL)) begin
				state_next.staged.pll_ctrl = cpmc_merge(state_reg.staged.pll_ctrl,
					pwdata_in, pstrb_in);
				state_next.pending = 1'b1;
			end else if (cpmc_hit(paddr_in, CPMC_IDX_VCO_DIV)) begin
				state_next.staged.vco_div = cpmc_merge(state_reg.staged.vco_div,
					pwdata_in, pstrb_in);
				state_next.pending = 1'b1;
			end else if (cpmc_hit(paddr_in, CPMC_IDX_SRC_SEL)) begin
				state_next.staged.src_sel = cpmc_merge(state_reg.staged.src_sel,
					pwdata_in, pstrb_in);
				state_next.pending = 1'b1;
			end
		end
		// The whole staged set moves at once, so no partial mix ever reaches the path.
		if (upd_fire) begin
			state_next.active = state_reg.staged;
			state_next.pending = 1'b0;
			state_next.applied = 1'b1;
		end
	end

	// Register the state; reset gives the power-up defaults of the clock path.
	// Reset is synchronous, so the analog side sees the PLL off from the edge
	// at which reset is first sampled high, never in the middle of a cycle.
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			state_reg.staged <= CPMC_CFG_RST;
			state_reg.active <= CPMC_CFG_RST;
			state_reg.pending <= 1'b0;
			state_reg.applied <= 1'b0;
			state_reg.ready <= 1'b0;
			state_reg.err <= 1'b0;
			state_reg.rdata <= 32'h0000_0000;
		end else begin
			state_reg <= state_next;
		end
	end

	// Path decoder; its outputs lag the active set by one registered cycle.
	cpmc_path_decode u_decode (
		.mclk_in(mclk_in),
		.srst_in(srst_in),
		.cfg_in(state_reg.active),
		.ctrl_out(ctrl_out)
	);

	// Bus answer and status outputs, straight from flip-flops except pslverr, which gates err with ready.
	assign pready_out = state_reg.ready;
	assign pslverr_out = state_reg.ready && state_reg.err;
	assign prdata_out = state_reg.rdata;
	assign update_pending_out = state_reg.pending;
	assign update_applied_out = state_reg.applied;

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (srst_in);

	chk_update_applies: assert property (
		upd_fire |=> state_reg.active == $past(state_reg.staged) ##1 ctrl_out.divider_bypass
			== $past(state_reg.staged.src_sel[CPMC_BYPASS_BIT], 2))
		else $error("Update command did not apply the staged settings.");
	chk_no_early_apply: assert property (
		!upd_fire |=> $stable(state_reg.active))
		else $error("Active settings changed without an update command.");
	chk_atomic_copy: assert property (
		$changed(state_reg.active) |-> $past(upd_fire) && update_applied_out
			&& !update_pending_out)
		else $error("Active set changed other than as one whole copy.");
	chk_reset_defaults: assert property (
		$past(srst_in) |-> state_reg.active == CPMC_CFG_RST && state_reg.staged == CPMC_CFG_RST)
		else $error("Configuration after reset is not the default set.");
	chk_staged_write: assert property (
		wr_fire && cpmc_hit(paddr_in, CPMC_IDX_PLL_CTRL) && pstrb_in[0]
			|=> state_reg.staged.pll_ctrl == $past(pwdata_in[7:0]) && update_pending_out)
		else $error("Write to the PLL control register was not staged.");
	chk_answer_timing: assert property (
		psel_in && !penable_in |=> pready_out)
		else $error("Setup cycle was not answered in the next cycle.");

	// Checks below follow the bus answer, the staging copy and the path
	// controls end to end, so a fault in either module shows up here too.

	// The answer stands for one cycle, so one transfer is never taken twice.
	chk_ready_pulse: assert property (
		pready_out |=> !pready_out)
		else $error("Bus answer stood for more than one cycle.");

	// An address that hits no register is refused with an error answer.
	chk_unmapped_error: assert property (
		setup_phase && !addr_mapped |=> pready_out && pslverr_out)
		else $error("Unmapped address was not answered with an error.");

	// The status word is read-only; a write to it is refused.
	chk_status_readonly: assert property (
		setup_phase && pwrite_in && cpmc_hit(paddr_in, CPMC_IDX_ACTIVE_STAT)
			|=> pready_out && pslverr_out)
		else $error("Write to the status word was not refused.");

	// A read of a mapped register is answered without an error.
	chk_mapped_read_ok: assert property (
		setup_phase && !pwrite_in && addr_mapped |=> !pslverr_out)
		else $error("Read of a mapped register was answered with an error.");

	// Writes return zero read data, so no stale value leaks onto the bus.
	chk_write_rdata_zero: assert property (
		setup_phase && pwrite_in |=> prdata_out == 32'h0000_0000)
		else $error("Write transfer returned nonzero read data.");

	// Reading a control register returns the staged byte, not the live one.
	chk_staged_readback: assert property (
		setup_phase && !pwrite_in && cpmc_hit(paddr_in, CPMC_IDX_PLL_CTRL)
			|=> prdata_out == {24'h00_0000, $past(state_reg.staged.pll_ctrl)})
		else $error("PLL control read did not return the staged byte.");

	// The update trigger acts on writes only and reads back as zero.
	chk_trigger_reads_zero: assert property (
		setup_phase && !pwrite_in && cpmc_hit(paddr_in, CPMC_IDX_UPDATE)
			|=> prdata_out == 32'h0000_0000 && !pslverr_out)
		else $error("Update trigger did not read back as zero.");

	// Divider and source writes are held back until the update command.
	chk_pending_on_write: assert property (
		wr_fire && (cpmc_hit(paddr_in, CPMC_IDX_VCO_DIV)
			|| cpmc_hit(paddr_in, CPMC_IDX_SRC_SEL))
			|=> update_pending_out && $stable(state_reg.active))
		else $error("Divider or source write was not held as pending.");

	// A write without lane zero strobed leaves every staged byte alone.
	chk_no_strobe_keeps: assert property (
		wr_fire && !pstrb_in[0] |=> $stable(state_reg.staged))
		else $error("Unstrobed write changed a staged byte.");

	// Only the exact command value applies; any other value is dropped.
	chk_wrong_command: assert property (
		wr_fire && cpmc_hit(paddr_in, CPMC_IDX_UPDATE)
			&& pwdata_in[7:0] != CPMC_UPDATE_CMD
			|=> $stable(state_reg.active) && !update_applied_out)
		else $error("A wrong update value changed the active settings.");

	// The applied flag is a single pulse and only an update raises it.
	chk_applied_pulse: assert property (
		update_applied_out |-> $past(upd_fire) ##1 !update_applied_out)
		else $error("Applied flag was not a single pulse after an update.");

	// Power state reaches the path two edges after the update command.
	chk_power_applied: assert property (
		upd_fire |-> ##2 ctrl_out.pll_power_down
			== ($past(state_reg.staged.pll_ctrl[1:0], 2) == CPMC_PWR_ASYNC_PD))
		else $error("Applied power field did not set the PLL state.");

	// Detector polarity reaches the path with the rest of the set.
	chk_polarity_applied: assert property (
		upd_fire |-> ##2 ctrl_out.phase_detector_negative
			== $past(state_reg.staged.pll_ctrl[CPMC_POL_BIT], 2))
		else $error("Applied polarity bit did not reach the detector.");

	// The clock source select reaches the path with the rest of the set.
	chk_source_applied: assert property (
		upd_fire |-> ##2 ctrl_out.source_internal
			== $past(state_reg.staged.src_sel[CPMC_SRC_BIT], 2))
		else $error("Applied source select did not reach the source mux.");

	// Divider ratio and pump mode follow the same update.
	chk_divider_applied: assert property (
		upd_fire |-> ##2 ctrl_out.vco_div_sel
			== $past(state_reg.staged.vco_div[2:0], 2)
			&& ctrl_out.loop_pump_mode == $past(state_reg.staged.pll_ctrl[6:4], 2))
		else $error("Applied divider or pump setting did not reach the path.");

	// With the active set still, the path controls never move on their own.
	chk_path_frozen: assert property (
		$stable(state_reg.active) |=> $stable(ctrl_out))
		else $error("Path controls moved without an applied update.");

	cov_update_fired: cover property (upd_fire);
	cov_bypass_mode: cover property (ctrl_out.divider_bypass && ctrl_out.pll_power_down);
	cov_pll_on_negative: cover property (ctrl_out.pll_normal && ctrl_out.phase_detector_negative);
	cov_unmapped_error: cover property (pready_out && pslverr_out);
	cov_wrong_command: cover property (wr_fire && cpmc_hit(paddr_in, CPMC_IDX_UPDATE) && !upd_fire);

endmodule

// ---- dv/cpmc_host_model.sv ----
/*
 * Host model: an APB master that issues one transfer at a time for the bench.
 * Assumes a slave on the same clock that answers within a few cycles.
 */
`timescale 1ns/1ns

module cpmc_host_model (
	input wire logic mclk_in,
	input wire logic pready_in,
	input wire logic [31:0] prdata_in,
	input wire logic pslverr_in,
	output logic psel_out,
	output logic penable_out,
	output logic pwrite_out,
	output logic [11:0] paddr_out,
	output logic [31:0] pwdata_out,
	output logic [3:0] pstrb_out
);
	// The bus idles low, so no request can appear while reset is held.
	initial begin
		psel_out = 1'b0;
		penable_out = 1'b0;
		pwrite_out = 1'b0;
		paddr_out = 12'h000;
		pwdata_out = 32'h0000_0000;
		pstrb_out = 4'h0;
	end

	// One transfer: setup, then access held until pready is sampled high.
	// The wait is bounded, and a hang comes back through the hung flag.
	task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
		input logic [3:0] strb, output logic [31:0] rdata, output logic err,
		output logic hung);
		bit got;
		got = 1'b0;
		rdata = 32'h0000_0000;
		err = 1'b0;
		@(posedge mclk_in);
		psel_out <= 1'b1;
		pwrite_out <= wr;
		paddr_out <= addr;
		pwdata_out <= wdata;
		pstrb_out <= strb;
		@(posedge mclk_in);
		penable_out <= 1'b1;
		for (int i = 0; i < 16 && !got; i++) begin
			@(posedge mclk_in);
			if (pready_in === 1'b1) begin
				got = 1'b1;
				rdata = prdata_in;
				err = pslverr_in;
			end
		end
		// Released address and data lines show the inverse, so stale values never look valid.
		psel_out <= 1'b0;
		penable_out <= 1'b0;
		paddr_out <= ~addr;
		pwdata_out <= ~wdata;
		hung = !got;
	endtask
endmodule

// ---- dv/cpmc_clock_path_mode_config_tb_top.sv ----
/*
 * Self-checking bench for the clock path mode configuration block.
 * Assumes the host model as APB master and the package's constants.
 */
`timescale 1ns/1ns

module cpmc_clock_path_mode_config_tb_top import cpmc_pkg::*; ();
	logic mclk_in;
	logic srst_in = 1'b1; // Reset is asserted from time zero.
	logic psel, penable, pwrite, pready, pslverr, pend, appl;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic err;
	cpmc_ctrl_s ctrl; // Decoded path controls seen at the ports.
	int n_errors = 0;
	int checked = 0;

	// A 20 MHz clock.
	initial begin
		mclk_in = 1'b0;
		forever #25 mclk_in = ~mclk_in;
	end

	cpmc_clock_path_mode_config cpmc_clock_path_mode_config_inst (.mclk_in(mclk_in),
		.srst_in(srst_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb), .pready_out(pready),
		.prdata_out(prdata), .pslverr_out(pslverr), .ctrl_out(ctrl),
		.update_pending_out(pend), .update_applied_out(appl));

	cpmc_host_model cpmc_host_model_inst (.mclk_in(mclk_in), .pready_in(pready),
		.prdata_in(prdata), .pslverr_in(pslverr), .psel_out(psel), .penable_out(penable),
		.pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata), .pstrb_out(pstrb));

	// Prints the verdict and ends the run; the only place that finishes.
	task automatic final_report();
		if (n_errors == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Compares with case inequality so an unknown never passes.
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic check_bit(input string what, input logic seen, input logic exp);
		check(what, {31'h0, seen}, {31'h0, exp});
	endtask

	// One register transfer by index; a hung bus ends the run as a failure.
	task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] d,
		input logic [3:0] s);
		logic hung;
		cpmc_host_model_inst.xfer(wr, {idx, 2'h0}, {24'h0, d}, s, rd, err, hung);
		if (hung) begin
			n_errors++;
			final_report();
		end
	endtask

	// Expected controls are decoded here from the register bytes.
	task automatic check_ctrl(input logic [7:0] pll, input logic [7:0] div, input logic [7:0] src);
		check_bit("power_down", ctrl.pll_power_down, pll[1:0] == CPMC_PWR_ASYNC_PD);
		check_bit("pll_normal", ctrl.pll_normal, pll[1:0] == CPMC_PWR_NORMAL);
		check_bit("pd_negative", ctrl.phase_detector_negative, pll[7]);
		check("vco_div_sel", {29'h0, ctrl.vco_div_sel}, {29'h0, div[2:0]});
		check("pump_mode", {29'h0, ctrl.loop_pump_mode}, {29'h0, pll[6:4]});
		check_bit("bypass", ctrl.divider_bypass, src[0]);
		check_bit("src_internal", ctrl.source_internal, src[1]);
	endtask

	// Applies the staged set and checks the pulse, then the new controls.
	task automatic apply(input logic [7:0] pll, input logic [7:0] div, input logic [7:0] src);
		bus(1'b1, CPMC_IDX_UPDATE, CPMC_UPDATE_CMD, 4'h1);
		@(negedge mclk_in);
		check_bit("applied", appl, 1'b1);
		check_bit("pending_clr", pend, 1'b0);
		@(negedge mclk_in);
		check_ctrl(pll, div, src);
		bus(1'b0, CPMC_IDX_ACTIVE_STAT, 8'h00, 4'h0);
		check("status", rd, {8'h00, pll, div, src});
	endtask

	// Defaults after reset: PLL off, divide by four, divider used, external clock.
	task automatic sc_defaults();
		@(negedge mclk_in);
		check_ctrl(CPMC_PLL_CTRL_RST, CPMC_VCO_DIV_RST, CPMC_SRC_SEL_RST);
		check_bit("pending_rst", pend, 1'b0);
		bus(1'b0, CPMC_IDX_ACTIVE_STAT, 8'h00, 4'h0);
		check("status_rst", rd, {8'h00, CPMC_PLL_CTRL_RST, CPMC_VCO_DIV_RST, 8'h00});
	endtask

	// PLL on with negative polarity and bypass; nothing moves before the update.
	task automatic sc_pll_bypass();
		bus(1'b1, CPMC_IDX_PLL_CTRL, 8'h80, 4'h1);
		bus(1'b1, CPMC_IDX_SRC_SEL, 8'h01, 4'h1);
		@(negedge mclk_in);
		check_bit("pending", pend, 1'b1);
		bus(1'b1, CPMC_IDX_UPDATE, 8'h02, 4'h1); // A wrong command is ignored.
		repeat (2) @(negedge mclk_in);
		check_ctrl(CPMC_PLL_CTRL_RST, CPMC_VCO_DIV_RST, CPMC_SRC_SEL_RST);
		bus(1'b0, CPMC_IDX_PLL_CTRL, 8'h00, 4'h0);
		check("staged_pll", rd, 32'h0000_0080);
		apply(8'h80, CPMC_VCO_DIV_RST, 8'h01);
	endtask

	// Distribution below the frequency limit with the PLL off and bypass set.
	task automatic sc_distribution();
		bus(1'b1, CPMC_IDX_PLL_CTRL, 8'h31, 4'h1);
		bus(1'b1, CPMC_IDX_VCO_DIV, 8'h05, 4'h1);
		bus(1'b1, CPMC_IDX_PLL_CTRL, 8'h80, 4'h0); // Lane 0 not strobed, so ignored.
		apply(8'h31, 8'h05, 8'h01);
	endtask

	// Unmapped and read-only places answer with an error and change nothing.
	task automatic sc_errors();
		bus(1'b0, 10'h3f0, 8'h00, 4'h0);
		check_bit("unmapped_err", err, 1'b1);
		check("unmapped_data", rd, 32'h0000_0000);
		bus(1'b1, CPMC_IDX_ACTIVE_STAT, 8'hff, 4'h1);
		check_bit("status_wr_err", err, 1'b1);
		bus(1'b0, CPMC_IDX_UPDATE, 8'h00, 4'h0);
		check("update_rd", rd, 32'h0000_0000);
		check_bit("update_rd_err", err, 1'b0);
	endtask

	// Internal source is applied, then a reset in mid-run restores defaults.
	task automatic sc_midreset();
		bus(1'b1, CPMC_IDX_SRC_SEL, 8'h02, 4'h1);
		apply(8'h31, 8'h05, 8'h02);
		bus(1'b1, CPMC_IDX_PLL_CTRL, 8'h80, 4'h1); // Leaves a pending write.
		@(posedge mclk_in);
		srst_in <= 1'b1;
		repeat (3) @(posedge mclk_in);
		srst_in <= 1'b0;
		sc_defaults();
	endtask

	// Main sequence: reset for three cycles, then every scenario in turn.
	initial begin
		repeat (3) @(posedge mclk_in);
		srst_in <= 1'b0;
		sc_defaults();
		sc_pll_bypass();
		sc_distribution();
		sc_errors();
		sc_midreset();
		final_report();
	end
endmodule
